/* src/uolc_pkg.sv */
package uolc_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STAT = 4'h4;
	localparam logic [3:0] OFS_TOKEN = 4'h8;
	localparam logic [3:0] OFS_EPEN = 4'hc;

	// ----------------------------------------------------------------
	// otg_control_reg fields
	// ----------------------------------------------------------------
	localparam int CTRL_HOST = 0;
	localparam int CTRL_LOWSPD = 1;
	localparam int CTRL_ENABLE = 2;
	localparam int CTRL_SUSPEND = 3;
	localparam int CTRL_DM_PD = 4;
	localparam int CTRL_DP_PD = 5;
	localparam int CTRL_DP_PU = 7;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// ----------------------------------------------------------------
	// status, token and endpoint enable fields
	// ----------------------------------------------------------------
	localparam int STAT_HOST = 0;
	localparam int STAT_LOWSPD = 1;
	localparam int STAT_VBUS = 2;
	localparam int STAT_BADTOK = 3;
	localparam int STAT_QLVL_LSB = 8;
	localparam int TOK_PID_LSB = 0;
	localparam int TOK_EP_LSB = 4;
	localparam logic [31:0] EPEN_RST = 32'h0001_0001;

	// ----------------------------------------------------------------
	// endpoints, queue and token codes
	// ----------------------------------------------------------------
	localparam int NUM_EP = 16;
	localparam int QDEPTH = 16;
	localparam int QW = 9;
	localparam int QLW = 5;
	localparam logic [3:0] PID_OUT = 4'h1;
	localparam logic [3:0] PID_IN = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hd;

endpackage

/* src/uolc_fifo.sv */
// depth must be a power of two: pointers wrap by overflow
module uolc_fifo #(
	parameter int W = 9,
	parameter int D = 16
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i,
	output logic [$clog2(D+1)-1:0] level_o
);
	localparam int AW = $clog2(D);
	localparam int LW = $clog2(D+1);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [LW-1:0] cnt_r;
	logic push;
	logic pop;

	assign in_ready_o = (cnt_r != LW'(D));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o = mem[rp_r];
	assign level_o = cnt_r;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			cnt_r <= cnt_r + LW'(push) - LW'(pop);
		end
	end
endmodule

/* src/uolc_dir.sv */
// token direction seen from the controller side
module uolc_dir
	import uolc_pkg::*;
(
	input wire logic host_i,
	input wire logic [3:0] pid_i,
	output logic known_o,
	output logic rx_o
);
	logic is_in;
	logic is_out;

	assign is_in = (pid_i == PID_IN);
	assign is_out = (pid_i == PID_OUT) || (pid_i == PID_SETUP);
	assign known_o = is_in || is_out;
	assign rx_o = host_i ? is_in : is_out;
endmodule

/* src/uolc_top.sv */
module uolc_top
	import uolc_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic vbus_i,
	output logic dp_pullup_o,
	output logic dp_pulldown_o,
	output logic dm_pulldown_o,
	output logic host_mode_o,
	output logic low_speed_o,
	output logic usb_enable_o,
	output logic suspend_o,
	output logic xfer_valid_o,
	output logic [3:0] xfer_ep_o,
	output logic xfer_rx_o,
	output logic [3:0] xfer_pid_o,
	input wire logic xfer_ready_i
);
	logic [7:0] ctrl_r;
	logic [31:0] epen_r;
	logic badtok_r;
	logic vbus_meta_r;
	logic vbus_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rd_nxt;
	logic out_valid_r;
	logic [QW-1:0] out_data_r;

	logic wr_ack;
	logic ctrl_wr;
	logic tok_wr;
	logic [3:0] tok_pid;
	logic [3:0] tok_ep;
	logic dir_known;
	logic dir_rx;
	logic ep_on;
	logic tok_ok;
	logic stall;
	logic q_push;
	logic [QW-1:0] q_in_data;
	logic q_in_ready;
	logic q_out_valid;
	logic q_out_ready;
	logic [QW-1:0] q_out_data;
	logic [QLW-1:0] q_level;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign wr_ack = avs_write_i && !wait_r;
	assign ctrl_wr = wr_ack && (avs_address_i == OFS_CTRL)
		&& avs_byteenable_i[0];
	assign tok_wr = avs_write_i && (avs_address_i == OFS_TOKEN)
		&& avs_byteenable_i[0];
	assign tok_pid = avs_writedata_i[TOK_PID_LSB +: 4];
	assign tok_ep = avs_writedata_i[TOK_EP_LSB +: 4];

	uolc_dir u_dir (
		.host_i(ctrl_r[CTRL_HOST]),
		.pid_i(tok_pid),
		.known_o(dir_known),
		.rx_o(dir_rx)
	);

	// rx directions sit in the low half, tx in the high half
	assign ep_on = epen_r[{!dir_rx, tok_ep}];
	// the far end picks the endpoint in host mode, so no enable check
	assign tok_ok = dir_known && ctrl_r[CTRL_ENABLE]
		&& (ctrl_r[CTRL_HOST] || ep_on);
	// a full queue holds the master off instead of losing the token
	assign stall = tok_wr && tok_ok && !q_in_ready;
	assign q_push = wr_ack && tok_wr && tok_ok;
	assign q_in_data = {tok_ep, dir_rx, tok_pid};

	// ----------------------------------------------------------------
	// waitrequest: one wait cycle per access, more while an accepted token stalls on a full queue
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wait_r <= 1'b1;
		end else if (!wait_r) begin
			wait_r <= 1'b1;
		end else if ((avs_read_i || avs_write_i) && !stall) begin
			wait_r <= 1'b0;
		end
	end

	always_comb begin
		rd_nxt = '0;
		case (avs_address_i)
			OFS_CTRL: begin
				rd_nxt[7:0] = ctrl_r;
			end
			OFS_STAT: begin
				rd_nxt[STAT_HOST] = ctrl_r[CTRL_HOST];
				rd_nxt[STAT_LOWSPD] = ctrl_r[CTRL_LOWSPD];
				rd_nxt[STAT_VBUS] = vbus_r;
				rd_nxt[STAT_BADTOK] = badtok_r;
				rd_nxt[STAT_QLVL_LSB +: QLW] = q_level;
			end
			OFS_EPEN: begin
				rd_nxt = epen_r;
			end
			default: begin
				rd_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_r <= '0;
		end else if (wait_r && avs_read_i) begin
			rdata_r <= rd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// control register and line configuration
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl_r <= CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_r <= avs_writedata_i[7:0];
			// low speed cannot be kept outside host mode
			ctrl_r[CTRL_LOWSPD] <= avs_writedata_i[CTRL_LOWSPD]
				&& avs_writedata_i[CTRL_HOST];
		end
	end

	// suspend has no path to the pull-up, so it stays as software left it
	assign dp_pullup_o = ctrl_r[CTRL_DP_PU];
	assign dp_pulldown_o = ctrl_r[CTRL_DP_PD];
	assign dm_pulldown_o = ctrl_r[CTRL_DM_PD];
	assign host_mode_o = ctrl_r[CTRL_HOST];
	assign low_speed_o = ctrl_r[CTRL_LOWSPD];
	assign usb_enable_o = ctrl_r[CTRL_ENABLE];
	assign suspend_o = ctrl_r[CTRL_SUSPEND];

	generate
		for (genvar b = 0; b < 4; b++) begin : g_epen
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					epen_r[b*8 +: 8] <= EPEN_RST[b*8 +: 8];
				end else if (wr_ack && (avs_address_i == OFS_EPEN)
						&& avs_byteenable_i[b]) begin
					epen_r[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// status: vbus sense and refused token flag
	// ----------------------------------------------------------------
	// vbus is only reported; software decides when to enable
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			vbus_meta_r <= 1'b0;
			vbus_r <= 1'b0;
		end else begin
			vbus_meta_r <= vbus_i;
			vbus_r <= vbus_meta_r;
		end
	end

	// a new refusal in the clearing cycle keeps the flag set
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			badtok_r <= 1'b0;
		end else if (wr_ack && tok_wr && !tok_ok) begin
			badtok_r <= 1'b1;
		end else if (wr_ack && (avs_address_i == OFS_STAT)
				&& avs_byteenable_i[0]
				&& avs_writedata_i[STAT_BADTOK]) begin
			badtok_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// transfer queue, one for both modes
	// ----------------------------------------------------------------
	uolc_fifo #(
		.W(QW),
		.D(QDEPTH)
	) u_queue (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.in_valid_i(q_push),
		.in_data_i(q_in_data),
		.in_ready_o(q_in_ready),
		.out_valid_o(q_out_valid),
		.out_data_o(q_out_data),
		.out_ready_i(q_out_ready),
		.level_o(q_level)
	);

	assign q_out_ready = !out_valid_r || xfer_ready_i;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			out_valid_r <= 1'b0;
			out_data_r <= '0;
		end else if (q_out_ready) begin
			out_valid_r <= q_out_valid;
			out_data_r <= q_out_data;
		end
	end

	assign xfer_valid_o = out_valid_r;
	assign xfer_pid_o = out_data_r[3:0];
	assign xfer_rx_o = out_data_r[4];
	assign xfer_ep_o = out_data_r[8:5];
	assign avs_readdata_o = rdata_r;
	assign avs_waitrequest_o = wait_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	property p_pullup;
		ctrl_wr |=> dp_pullup_o == $past(avs_writedata_i[CTRL_DP_PU]);
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("pull-up does not follow control write");

	property p_pulldown;
		ctrl_wr |=> (dp_pulldown_o == $past(avs_writedata_i[CTRL_DP_PD]))
			&& (dm_pulldown_o == $past(avs_writedata_i[CTRL_DM_PD]));
	endproperty
	a_pulldown: assert property (p_pulldown)
		else $error("pull-downs do not follow control write");

	property p_dir;
		q_push && (tok_pid == PID_IN) |-> q_in_data[4] == host_mode_o;
	endproperty
	a_dir: assert property (p_dir)
		else $error("IN token given wrong direction");

	property p_lowspd;
		low_speed_o |-> host_mode_o;
	endproperty
	a_lowspd: assert property (p_lowspd)
		else $error("low speed outside host mode");

	property p_mode;
		ctrl_wr |=> ##1 host_mode_o == $past(avs_writedata_i[CTRL_HOST], 2)
			|| $past(ctrl_wr);
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode switch not taken");

	property p_qfull;
		tok_wr && tok_ok && (q_level == QLW'(QDEPTH)) |-> avs_waitrequest_o;
	endproperty
	a_qfull: assert property (p_qfull)
		else $error("token accepted into full queue");

	property p_suspend;
		suspend_o && !ctrl_wr |=> $stable(dp_pullup_o);
	endproperty
	a_suspend: assert property (p_suspend)
		else $error("pull-up changed during suspend");

	property p_read;
		avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_read: assert property (p_read)
		else $error("read not answered after one wait cycle");

	property p_push_level;
		q_push && !(q_out_valid && q_out_ready) |=>
			q_level == $past(q_level) + 1'b1;
	endproperty
	a_push_level: assert property (p_push_level)
		else $error("queued token lost");
endmodule

/* sim/uolc_sink.sv */
// ----------------------------------------------------------------
// consumer of the transfer stream on the far side
// ----------------------------------------------------------------
module uolc_sink (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic hold_i,
	output logic xfer_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 32'h743e;
	initial xfer_ready_o = 1'b0;
	// ready mixes prompt and slow takes; hold stalls it fully
	always @(posedge clk_i) begin
		xfer_ready_o <= !reset_i && !hold_i && (($random(seed) & 3) != 0);
	end
endmodule

/* sim/uolc_top_tb.sv */
module uolc_top_tb
	import uolc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic vbus = 1'b0;
	logic hold = 1'b1;
	logic [3:0] be = 4'hf;
	logic [31:0] rdat;
	logic wreq, pu, pdp, pdm, hm, ls, en, sus, xv, xrx, xrdy;
	logic [3:0] xep, xpid;
	logic [3:0] pids [3] = '{PID_OUT, PID_IN, PID_SETUP};
	logic [8:0] xq [$];
	logic [31:0] rq [$];
	int n_fail = 0;
	int n_compared = 0;
	int seed = 32'h743e;

	always #2.5 clk_i = ~clk_i;

	uolc_top u_uolc_top (.clk_i(clk_i), .reset_i(reset_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_byteenable_i(be), .avs_writedata_i(wd),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
		.vbus_i(vbus), .dp_pullup_o(pu), .dp_pulldown_o(pdp),
		.dm_pulldown_o(pdm), .host_mode_o(hm), .low_speed_o(ls),
		.usb_enable_o(en), .suspend_o(sus), .xfer_valid_o(xv),
		.xfer_ep_o(xep), .xfer_rx_o(xrx), .xfer_pid_o(xpid),
		.xfer_ready_i(xrdy));
	uolc_sink u_uolc_sink (.clk_i(clk_i), .reset_i(reset_i),
		.hold_i(hold), .xfer_ready_o(xrdy));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		if (n_fail == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// request held until the edge that samples waitrequest low
	task automatic bus(input logic w, input logic [3:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wr <= w;
		rd <= !w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wreq !== 1'b0 && n < 2000);
		if (n >= 2000) n_fail++;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic rdx(input logic [3:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic tok(input logic [3:0] pid, input logic [3:0] ep,
			input logic rx);
		xq.push_back({ep, rx, pid});
		bus(1'b1, OFS_TOKEN, {24'h0, ep, pid});
	endtask

	task automatic pins(input logic [6:0] e);
		repeat (2) @(posedge clk_i);
		#1;
		check({25'h0, pu, pdp, pdm, hm, ls, en, sus}, {25'h0, e});
	endtask

	task automatic drain;
		int n;
		n = 0;
		while (xq.size() != 0 && n < 500) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 500) n_fail++;
	endtask

	// ----------------------------------------------------------------
	// result watcher: an unexpected result never matches
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rd && wreq === 1'b0)
			check(rdat, rq.size() ? rq.pop_front() : rdat ^ 32'h1);
		if (xv === 1'b1 && xrdy)
			check({23'h0, xep, xrx, xpid},
				xq.size() ? {23'h0, xq.pop_front()} : 32'hffff_ffff);
	end

	initial begin
		#100000;
		n_fail++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int i;
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		pins(7'h00);
		rdx(OFS_CTRL, 32'h0);
		rdx(OFS_EPEN, EPEN_RST);
		rdx(4'h1, 32'h0);
		rdx(OFS_TOKEN, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h80);
		pins(7'h40);
		bus(1'b1, OFS_CTRL, 32'h88);
		pins(7'h41);
		bus(1'b1, OFS_CTRL, 32'h33);
		pins(7'h3c);
		bus(1'b1, OFS_CTRL, 32'h02);
		pins(7'h00);
		vbus <= 1'b1;
		repeat (4) @(posedge clk_i);
		bus(1'b1, OFS_CTRL, 32'h84);
		pins(7'h42);
		tok(PID_OUT, 4'h0, 1'b1);
		bus(1'b1, OFS_EPEN, 32'hffff_ffff);
		// one word parks in the output stage, so 16 more fill the queue
		for (i = 1; i < 17; i++)
			tok(pids[i % 3], 4'($random(seed)), pids[i % 3] != PID_IN);
		rdx(OFS_STAT, 32'h0000_1004);
		fork
			tok(PID_SETUP, 4'hf, 1'b1);
			begin
				repeat (20) @(posedge clk_i);
				hold <= 1'b0;
			end
		join
		drain();
		rdx(OFS_STAT, 32'h0000_0004);
		bus(1'b1, OFS_EPEN, 32'h0);
		be <= 4'h2;
		bus(1'b1, OFS_EPEN, 32'hffff_ffff);
		be <= 4'hf;
		rdx(OFS_EPEN, 32'h0000_ff00);
		bus(1'b1, OFS_CTRL, 32'h35);
		for (i = 0; i < 6; i++)
			tok(pids[i % 3], 4'($random(seed)), pids[i % 3] == PID_IN);
		drain();
		bus(1'b1, OFS_TOKEN, 32'h52);
		rdx(OFS_STAT, 32'h0000_000d);
		bus(1'b1, OFS_STAT, 32'h8);
		rdx(OFS_STAT, 32'h0000_0005);
		bus(1'b1, OFS_CTRL, 32'h84);
		bus(1'b1, OFS_TOKEN, 32'h31);
		rdx(OFS_STAT, 32'h0000_000c);
		bus(1'b1, OFS_STAT, 32'h8);
		bus(1'b1, OFS_CTRL, 32'h01);
		bus(1'b1, OFS_TOKEN, 32'h09);
		rdx(OFS_STAT, 32'h0000_000d);
		repeat (10) @(posedge clk_i);
		wrap_up();
	end
endmodule
